/* File: rtl/rdv_pkg.sv */
/*
  Shared constants and types for the regulator enable, voltage-select and slew control.
  Assumes a single 20 MHz clock and a 32-bit AXI4-Lite register port.
*/
package rdv_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS   = 50;
  localparam int TICK_NS  = 1000;
  localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam int BIAS_NS  = 85000;
  localparam int BIAS_CYC = (BIAS_NS + CLK_NS - 1) / CLK_NS;

  // ----------------------------------------------------------------
  // Voltage model, one level step is 3.125 mV
  // ----------------------------------------------------------------
  localparam int              LVL_W        = 12;
  localparam int              CODE_W       = 7;
  localparam logic [11:0]     LVL_BASE     = 12'h340;
  localparam logic [11:0]     LVL_PER_CODE = 12'h004;
  localparam logic [11:0]     RISE_SLOW    = 12'h004;
  localparam logic [11:0]     RISE_FAST    = 12'h008;
  localparam logic [11:0]     FALL_SLOW    = 12'h001;
  localparam logic [11:0]     FALL_FAST    = 12'h002;
  localparam logic [15:0]     PG_NUM       = 16'h0009;
  localparam logic [15:0]     PG_DEN       = 16'h000a;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int              ADDR_W       = 8;
  localparam logic [7:0]      OFS_CTRL     = 8'h00;
  localparam logic [7:0]      OFS_VSEL0    = 8'h04;
  localparam logic [7:0]      OFS_VSEL1    = 8'h08;
  localparam logic [7:0]      OFS_STATUS   = 8'h0c;
  localparam logic [7:0]      OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0]      OFS_IRQ_MASK = 8'h14;

  localparam int              CTRL_EN_BIT   = 0;
  localparam int              CTRL_RISE_BIT = 1;
  localparam int              CTRL_FALL_BIT = 2;
  localparam logic [2:0]      CTRL_RST      = 3'h1;
  localparam logic [6:0]      VSEL0_RST     = 7'h38;
  localparam logic [6:0]      VSEL1_RST     = 7'h40;

  localparam int              IRQ_W         = 3;
  localparam int              IRQ_FAULT     = 0;
  localparam int              IRQ_PG        = 1;
  localparam int              IRQ_SS        = 2;
  localparam logic [2:0]      IRQ_MASK_RST  = 3'h0;

  localparam logic [1:0]      RESP_OKAY     = 2'h0;
  localparam logic [1:0]      RESP_SLVERR   = 2'h2;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_OFF,
    ST_BIAS,
    ST_IDLE,
    ST_SOFT,
    ST_REG
  } rdv_state_t;

endpackage : rdv_pkg

/* File: rtl/rdv_ramp.sv */
/*
  Output level ramp: moves the level toward the target once per microsecond.
  Assumes the caller holds run low while the regulator is off.
*/
`timescale 1ns/1ns
`default_nettype none

module rdv_ramp #(
  parameter int LVL_W = rdv_pkg::LVL_W
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             run,
  input  wire logic             rise_fast,
  input  wire logic             fall_fast,
  input  wire logic [LVL_W-1:0] target,
  output logic      [LVL_W-1:0] level,
  output logic                  at_target
);
  import rdv_pkg::*;

  localparam int TW = $clog2(TICK_CYC);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYC - 1);

  logic [TW-1:0]    tick_ff;
  logic [TW-1:0]    nxt_tick;
  logic [LVL_W-1:0] level_ff;
  logic [LVL_W-1:0] nxt_level;
  logic             at_ff;
  logic             nxt_at;
  logic [LVL_W-1:0] step_up;
  logic [LVL_W-1:0] step_dn;

  // ----------------------------------------------------------------
  // Ramp step
  // ----------------------------------------------------------------
  always_comb begin
    step_up   = rise_fast ? LVL_W'(RISE_FAST) : LVL_W'(RISE_SLOW);
    step_dn   = fall_fast ? LVL_W'(FALL_FAST) : LVL_W'(FALL_SLOW);
    nxt_tick  = tick_ff;
    nxt_level = level_ff;
    if (!run) begin
      nxt_tick  = '0;
      nxt_level = '0;
    end else if (tick_ff == TICK_LAST) begin
      nxt_tick = '0;
      if (level_ff < target) begin
        if ((target - level_ff) > step_up) begin
          nxt_level = level_ff + step_up;
        end else begin
          nxt_level = target;
        end
      end else if (level_ff > target) begin
        if ((level_ff - target) > step_dn) begin
          nxt_level = level_ff - step_dn;
        end else begin
          nxt_level = target;
        end
      end
    end else begin
      nxt_tick = tick_ff + TW'(1);
    end
    nxt_at = run && (nxt_level == target);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tick_ff  <= '0;
      level_ff <= '0;
      at_ff    <= 1'b0;
    end else if (ce) begin
      tick_ff  <= nxt_tick;
      level_ff <= nxt_level;
      at_ff    <= nxt_at;
    end
  end

  assign level     = level_ff;
  assign at_target = at_ff;

endmodule : rdv_ramp

`default_nettype wire

/* File: rtl/rdv_regulator_ctrl.sv */
/*
  Regulator enable sequencing, voltage selection, slew control, power-good and
  AXI4-Lite control registers with a masked interrupt.
  Assumes all pins and fault flags are synchronous to clk and a 20 MHz clock.
*/
`timescale 1ns/1ns
`default_nettype none

module rdv_regulator_ctrl #(
  parameter bit PG_ACTIVE_HIGH = 1'b1
) (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      ce,
  input  wire logic                      enable_pin,
  input  wire logic                      voltage_select_pin,
  input  wire logic                      over_temp,
  input  wire logic                      supply_undervoltage_lockout,
  input  wire logic                      over_current,
  input  wire logic [rdv_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [rdv_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  output logic                           regulator_on,
  output logic [rdv_pkg::LVL_W-1:0]      vout_level,
  output logic                           power_good_out,
  output logic                           power_good_oe,
  output logic                           irq
);
  import rdv_pkg::*;

  localparam int BW = $clog2(BIAS_CYC);
  localparam logic [BW-1:0] BIAS_LAST = BW'(BIAS_CYC - 1);
  localparam logic PG_OE_RST = PG_ACTIVE_HIGH;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] awaddr_ff, nxt_awaddr;
  logic              aw_have_ff, nxt_aw_have;
  logic [31:0]       wdata_ff, nxt_wdata;
  logic              wstrb0_ff, nxt_wstrb0;
  logic              w_have_ff, nxt_w_have;
  logic              awready_ff, nxt_awready;
  logic              wready_ff, nxt_wready;
  logic              bvalid_ff, nxt_bvalid;
  logic [1:0]        bresp_ff, nxt_bresp;
  logic              arready_ff, nxt_arready;
  logic              rvalid_ff, nxt_rvalid;
  logic [1:0]        rresp_ff, nxt_rresp;
  logic [31:0]       rdata_ff, nxt_rdata;
  logic              do_write;
  logic              wr_hit;
  logic              wr_ctrl, wr_vsel0, wr_vsel1, wr_istat, wr_imask;
  logic              rd_hit;
  logic [31:0]       rd_word;

  rdv_state_t        state_ff, nxt_state;
  logic [BW-1:0]     bias_cnt_ff, nxt_bias_cnt;
  logic [2:0]        ctrl_ff, nxt_ctrl;
  logic [6:0]        vsel0_ff, nxt_vsel0;
  logic [6:0]        vsel1_ff, nxt_vsel1;
  logic              sel_latch_ff, nxt_sel_latch;
  logic              fault_prev_ff, nxt_fault_prev;
  logic              reg_on_ff, nxt_reg_on;
  logic              pg_ff, nxt_pg;
  logic              pg_oe_ff, nxt_pg_oe;
  logic              pg_drv_ff, nxt_pg_drv;
  logic [IRQ_W-1:0]  istat_ff, nxt_istat;
  logic [IRQ_W-1:0]  imask_ff, nxt_imask;
  logic              irq_ff, nxt_irq;
  logic [IRQ_W-1:0]  events;
  logic [IRQ_W-1:0]  iclr;
  logic              fault;
  logic              sel_eff;
  logic [6:0]        code;
  logic [LVL_W-1:0]  target;
  logic [LVL_W-1:0]  level;
  logic              at_target;
  logic              pg_level_ok;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  always_comb begin
    wr_ctrl  = 1'b0;
    wr_vsel0 = 1'b0;
    wr_vsel1 = 1'b0;
    wr_istat = 1'b0;
    wr_imask = 1'b0;
    wr_hit   = 1'b1;
    if (awaddr_ff == OFS_CTRL) begin
      wr_ctrl = 1'b1;
    end else if (awaddr_ff == OFS_VSEL0) begin
      wr_vsel0 = 1'b1;
    end else if (awaddr_ff == OFS_VSEL1) begin
      wr_vsel1 = 1'b1;
    end else if (awaddr_ff == OFS_STATUS) begin
      wr_hit = 1'b1;
    end else if (awaddr_ff == OFS_IRQ_STAT) begin
      wr_istat = 1'b1;
    end else if (awaddr_ff == OFS_IRQ_MASK) begin
      wr_imask = 1'b1;
    end else begin
      wr_hit = 1'b0;
    end
    rd_hit  = 1'b1;
    rd_word = 32'h0;
    if (s_axi_araddr == OFS_CTRL) begin
      rd_word = {29'h0, ctrl_ff};
    end else if (s_axi_araddr == OFS_VSEL0) begin
      rd_word = {25'h0, vsel0_ff};
    end else if (s_axi_araddr == OFS_VSEL1) begin
      rd_word = {25'h0, vsel1_ff};
    end else if (s_axi_araddr == OFS_STATUS) begin
      rd_word = {4'h0, level, 11'h0, sel_latch_ff, pg_ff, (state_ff == ST_REG), reg_on_ff,
                 (state_ff != ST_OFF) && (state_ff != ST_BIAS)};
    end else if (s_axi_araddr == OFS_IRQ_STAT) begin
      rd_word = {29'h0, istat_ff};
    end else if (s_axi_araddr == OFS_IRQ_MASK) begin
      rd_word = {29'h0, imask_ff};
    end else begin
      rd_hit = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write and read channels
  // ----------------------------------------------------------------
  assign do_write = aw_have_ff && w_have_ff && !bvalid_ff;

  always_comb begin
    nxt_awaddr  = awaddr_ff;
    nxt_aw_have = aw_have_ff;
    nxt_wdata   = wdata_ff;
    nxt_wstrb0  = wstrb0_ff;
    nxt_w_have  = w_have_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_bresp   = bresp_ff;
    if (s_axi_awvalid && awready_ff) begin
      nxt_awaddr  = s_axi_awaddr;
      nxt_aw_have = 1'b1;
    end
    if (s_axi_wvalid && wready_ff) begin
      nxt_wdata  = s_axi_wdata;
      nxt_wstrb0 = s_axi_wstrb[0];
      nxt_w_have = 1'b1;
    end
    if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    if (do_write) begin
      nxt_aw_have = 1'b0;
      nxt_w_have  = 1'b0;
      nxt_bvalid  = 1'b1;
      nxt_bresp   = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    nxt_awready = !nxt_aw_have && !nxt_bvalid;
    nxt_wready  = !nxt_w_have && !nxt_bvalid;
    nxt_rvalid  = rvalid_ff;
    nxt_rdata   = rdata_ff;
    nxt_rresp   = rresp_ff;
    if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
    if (s_axi_arvalid && arready_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rdata  = rd_word;
      nxt_rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    nxt_arready = !nxt_rvalid;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      awaddr_ff  <= '0;
      aw_have_ff <= 1'b0;
      wdata_ff   <= 32'h0;
      wstrb0_ff  <= 1'b0;
      w_have_ff  <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0;
      rresp_ff   <= RESP_OKAY;
    end else if (ce) begin
      awaddr_ff  <= nxt_awaddr;
      aw_have_ff <= nxt_aw_have;
      wdata_ff   <= nxt_wdata;
      wstrb0_ff  <= nxt_wstrb0;
      w_have_ff  <= nxt_w_have;
      awready_ff <= nxt_awready;
      wready_ff  <= nxt_wready;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
      arready_ff <= nxt_arready;
      rvalid_ff  <= nxt_rvalid;
      rdata_ff   <= nxt_rdata;
      rresp_ff   <= nxt_rresp;
    end
  end

  // ----------------------------------------------------------------
  // Target selection and output ramp
  // ----------------------------------------------------------------
  assign fault   = over_temp || supply_undervoltage_lockout || over_current;
  assign sel_eff = (state_ff == ST_REG) ? voltage_select_pin : sel_latch_ff;
  assign code    = sel_eff ? vsel1_ff : vsel0_ff;
  assign target  = LVL_BASE + (LVL_W'(code) * LVL_PER_CODE);
  assign pg_level_ok = ({4'h0, level} * PG_DEN) >= ({4'h0, target} * PG_NUM);

  rdv_ramp #(
    .LVL_W     (LVL_W)
  ) u_ramp (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .run       (reg_on_ff),
    .rise_fast (ctrl_ff[CTRL_RISE_BIT]),
    .fall_fast (ctrl_ff[CTRL_FALL_BIT]),
    .target    (target),
    .level     (level),
    .at_target (at_target)
  );

  // ----------------------------------------------------------------
  // Sequencer, control registers and interrupt
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state      = state_ff;
    nxt_bias_cnt   = bias_cnt_ff;
    nxt_sel_latch  = sel_latch_ff;
    nxt_ctrl       = ctrl_ff;
    nxt_vsel0      = vsel0_ff;
    nxt_vsel1      = vsel1_ff;
    nxt_imask      = imask_ff;
    nxt_fault_prev = fault;
    iclr           = '0;
    if (do_write && wstrb0_ff) begin
      if (wr_ctrl) begin
        nxt_ctrl = wdata_ff[2:0];
      end
      if (wr_vsel0) begin
        nxt_vsel0 = wdata_ff[6:0];
      end
      if (wr_vsel1) begin
        nxt_vsel1 = wdata_ff[6:0];
      end
      if (wr_istat) begin
        iclr = wdata_ff[IRQ_W-1:0];
      end
      if (wr_imask) begin
        nxt_imask = wdata_ff[IRQ_W-1:0];
      end
    end
    case (state_ff)
      ST_OFF: begin
        nxt_bias_cnt = '0;
        if (enable_pin) begin
          nxt_state     = ST_BIAS;
          nxt_sel_latch = voltage_select_pin;
        end
      end
      ST_BIAS: begin
        nxt_bias_cnt = bias_cnt_ff + BW'(1);
        if (bias_cnt_ff == BIAS_LAST) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (ctrl_ff[CTRL_EN_BIT] && !fault) begin
          nxt_state = ST_SOFT;
        end
      end
      ST_SOFT: begin
        if (fault || !ctrl_ff[CTRL_EN_BIT]) begin
          nxt_state     = ST_IDLE;
          nxt_sel_latch = voltage_select_pin;
        end else if (at_target) begin
          nxt_state = ST_REG;
        end
      end
      ST_REG: begin
        if (fault || !ctrl_ff[CTRL_EN_BIT]) begin
          nxt_state     = ST_IDLE;
          nxt_sel_latch = voltage_select_pin;
        end
      end
      default: begin
        nxt_state = ST_OFF;
      end
    endcase
    if (!enable_pin) begin
      nxt_state = ST_OFF;
      nxt_ctrl  = CTRL_RST;
      nxt_vsel0 = VSEL0_RST;
      nxt_vsel1 = VSEL1_RST;
    end
    nxt_reg_on = (nxt_state == ST_SOFT) || (nxt_state == ST_REG);
    nxt_pg     = nxt_reg_on && reg_on_ff && pg_level_ok;
    nxt_pg_oe  = PG_ACTIVE_HIGH ? !nxt_pg : nxt_pg;
    nxt_pg_drv = 1'b0;
    events            = '0;
    events[IRQ_FAULT] = fault && !fault_prev_ff;
    events[IRQ_PG]    = nxt_pg && !pg_ff;
    events[IRQ_SS]    = (state_ff == ST_SOFT) && (nxt_state == ST_REG);
    nxt_istat = (istat_ff & ~iclr) | events;
    nxt_irq   = |(nxt_istat & nxt_imask);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff      <= ST_OFF;
      bias_cnt_ff   <= '0;
      sel_latch_ff  <= 1'b0;
      ctrl_ff       <= CTRL_RST;
      vsel0_ff      <= VSEL0_RST;
      vsel1_ff      <= VSEL1_RST;
      fault_prev_ff <= 1'b0;
      reg_on_ff     <= 1'b0;
      pg_ff         <= 1'b0;
      pg_oe_ff      <= PG_OE_RST;
      pg_drv_ff     <= 1'b0;
      istat_ff      <= '0;
      imask_ff      <= IRQ_MASK_RST;
      irq_ff        <= 1'b0;
    end else if (ce) begin
      state_ff      <= nxt_state;
      bias_cnt_ff   <= nxt_bias_cnt;
      sel_latch_ff  <= nxt_sel_latch;
      ctrl_ff       <= nxt_ctrl;
      vsel0_ff      <= nxt_vsel0;
      vsel1_ff      <= nxt_vsel1;
      fault_prev_ff <= nxt_fault_prev;
      reg_on_ff     <= nxt_reg_on;
      pg_ff         <= nxt_pg;
      pg_oe_ff      <= nxt_pg_oe;
      pg_drv_ff     <= nxt_pg_drv;
      istat_ff      <= nxt_istat;
      imask_ff      <= nxt_imask;
      irq_ff        <= nxt_irq;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_awready  = awready_ff;
  assign s_axi_wready   = wready_ff;
  assign s_axi_bvalid   = bvalid_ff;
  assign s_axi_bresp    = bresp_ff;
  assign s_axi_arready  = arready_ff;
  assign s_axi_rvalid   = rvalid_ff;
  assign s_axi_rdata    = rdata_ff;
  assign s_axi_rresp    = rresp_ff;
  assign regulator_on   = reg_on_ff;
  assign vout_level     = level;
  assign power_good_out = pg_drv_ff;
  assign power_good_oe  = pg_oe_ff;
  assign irq            = irq_ff;

endmodule : rdv_regulator_ctrl

`default_nettype wire

/* File: test/rdv_ctrl_sva.sv */
/* Port assertions for the regulator control block.
   Bound into rdv_regulator_ctrl; one clock, synchronous reset. */
`timescale 1ns/1ns
`default_nettype none
module rdv_ctrl_sva
  import rdv_pkg::*;
#(
  parameter bit PG_ACTIVE_HIGH = 1'b1
) (
  input wire logic             clk,
  input wire logic             rst,
  input wire logic             enable_pin,
  input wire logic             over_temp,
  input wire logic             supply_undervoltage_lockout,
  input wire logic             over_current,
  input wire logic             regulator_on,
  input wire logic [LVL_W-1:0] vout_level,
  input wire logic             power_good_out,
  input wire logic             power_good_oe
);
  logic        fault;
  logic [11:0] en_cnt_ff;
  assign fault = over_temp || supply_undervoltage_lockout || over_current;
  // Cycles since the enable pin went high
  always_ff @(posedge clk) begin
    if (rst || !enable_pin) begin
      en_cnt_ff <= 12'h000;
    end else if (en_cnt_ff != 12'hfff) begin
      en_cnt_ff <= en_cnt_ff + 12'h001;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_ramp;
    regulator_on && $past(regulator_on);
  endsequence
  a_bias_wait: assert property (regulator_on |-> en_cnt_ff >= BIAS_CYC)
    else $error("regulator on before bias settled");
  a_pin_low_off: assert property (!enable_pin [*3] |-> !regulator_on)
    else $error("regulator on with enable pin low");
  a_fault_off: assert property (fault [*3] |-> !regulator_on)
    else $error("regulator on during fault");
  a_pg_disabled: assert property (!regulator_on [*2] |-> power_good_oe == PG_ACTIVE_HIGH)
    else $error("power good asserted while off");
  a_pg_drive: assert property (power_good_out == 1'b0)
    else $error("open-drain pin driven high");
  a_pg_level: assert property (power_good_oe != PG_ACTIVE_HIGH |->
    vout_level >= 12'd749 || $past(vout_level) >= 12'd749)
    else $error("power good below threshold");
  a_rise_step: assert property (s_ramp ##0 vout_level > $past(vout_level) |->
    vout_level - $past(vout_level) <= 12'd8)
    else $error("rise step too large");
  a_fall_step: assert property (s_ramp ##0 vout_level < $past(vout_level) |->
    $past(vout_level) - vout_level <= 12'd2)
    else $error("fall step too large");
  a_step_gap: assert property (s_ramp ##0 vout_level != $past(vout_level) |=>
    ($stable(vout_level) || !regulator_on) [*8])
    else $error("ramp steps too close");
endmodule : rdv_ctrl_sva
bind rdv_regulator_ctrl rdv_ctrl_sva #(.PG_ACTIVE_HIGH(PG_ACTIVE_HIGH)) u_sva (
  .clk(clk), .rst(rst), .enable_pin(enable_pin), .over_temp(over_temp),
  .supply_undervoltage_lockout(supply_undervoltage_lockout), .over_current(over_current),
  .regulator_on(regulator_on), .vout_level(vout_level),
  .power_good_out(power_good_out), .power_good_oe(power_good_oe));
`default_nettype wire

/* File: test/rdv_host_model.sv */
/* Host pin driver: registers enable and select requests onto the pins.
   Assumes requests change just after a rising edge of clk. */
`timescale 1ns/1ns
`default_nettype none
module rdv_host_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic en_req,
  input wire logic sel_req,
  output logic     enable_pin,
  output logic     voltage_select_pin
);
  always_ff @(posedge clk) begin
    if (rst) begin
      enable_pin         <= 1'b0;
      voltage_select_pin <= 1'b0;
    end else begin
      enable_pin         <= en_req;
      voltage_select_pin <= sel_req;
    end
  end
endmodule : rdv_host_model
`default_nettype wire

/* File: test/tb_top.sv */
/* Self-checking bench for the regulator control block.
   Assumes the host model and the bound port checker. */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import rdv_pkg::*;
  localparam logic [11:0] T0 = LVL_BASE + LVL_PER_CODE * VSEL0_RST;
  localparam logic [11:0] T1 = LVL_BASE + LVL_PER_CODE * VSEL1_RST;
  logic        clk = 1'b0, rst = 1'b1, en_req = 1'b0, sel_req = 1'b0, ce = 1'b1;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [2:0]  flt = 3'h0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [1:0]  bresp, rresp, resp;
  logic        enable_pin, voltage_select_pin, awready, wready, bvalid, arready, rvalid;
  logic        reg_on, pg_out, pg_oe, irq;
  logic [11:0] lvl;
  int          fails = 0, check_count = 0, cyc = 0, n;

  rdv_host_model u_host (.clk(clk), .rst(rst), .en_req(en_req), .sel_req(sel_req),
    .enable_pin(enable_pin), .voltage_select_pin(voltage_select_pin));
  rdv_regulator_ctrl u_dut (.clk(clk), .rst(rst), .ce(ce), .enable_pin(enable_pin),
    .voltage_select_pin(voltage_select_pin), .over_temp(flt[0]),
    .supply_undervoltage_lockout(flt[1]), .over_current(flt[2]),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .regulator_on(reg_on), .vout_level(lvl), .power_good_out(pg_out),
    .power_good_oe(pg_oe), .irq(irq));

  initial begin
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      wrap_up();
    end
  end

  task wrap_up();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : rd

  task wait_on(input logic v, input int max);
    n = 0;
    while (reg_on !== v && n < max) begin
      @(posedge clk);
      n++;
    end
  endtask : wait_on

  task wait_lvl(input logic [11:0] v);
    n = 0;
    while (lvl !== v && n < 8000) begin
      @(posedge clk);
      n++;
    end
  endtask : wait_lvl

  // Measures one ramp step: size and spacing in cycles
  task step_chk(input logic [11:0] dl, input bit up);
    logic [11:0] a;
    for (int k = 0; k < 2; k++) begin
      a = lvl;
      n = 0;
      while (lvl === a && n < 100) begin
        @(posedge clk);
        n++;
      end
    end
    chk(n, TICK_CYC);
    chk({20'h0, up ? lvl - a : a - lvl}, dl);
  endtask : step_chk

  task t_reset();
    chk(reg_on, 1'b0);
    chk(pg_oe, 1'b1);
    rd(OFS_CTRL);
    chk(d, 32'h1);
    rd(8'h20);
    chk(resp, RESP_SLVERR);
    wr(8'h20, 32'h0);
    chk(resp, RESP_SLVERR);
    $display("test reset done");
  endtask : t_reset

  task t_power_up();
    sel_req <= 1'b1;
    en_req  <= 1'b1;
    wait_on(1'b1, 2000);
    chk(n >= BIAS_CYC && n <= BIAS_CYC + 10, 1'b1);
    chk(pg_oe, 1'b1);
    step_chk(12'd4, 1'b1);
    sel_req <= 1'b0;
    wait_lvl(T1);
    chk(lvl, T1);
    step_chk(12'd1, 1'b0);
    wait_lvl(T0);
    repeat (3) @(posedge clk);
    chk(pg_oe, 1'b0);
    rd(OFS_STATUS);
    chk(d, {4'h0, T0, 16'h001f});
    rd(OFS_IRQ_STAT);
    chk(d, 32'h6);
    wr(OFS_CTRL, 32'h7);
    chk(resp, RESP_OKAY);
    sel_req <= 1'b1;
    step_chk(12'd8, 1'b1);
    wait_lvl(T1);
    sel_req <= 1'b0;
    step_chk(12'd2, 1'b0);
    wait_lvl(T0);
    chk(lvl, T0);
    $display("test power-up done");
  endtask : t_power_up

  task t_sw_bit();
    wr(OFS_CTRL, 32'h6);
    wait_on(1'b0, 10);
    chk(reg_on, 1'b0);
    repeat (3) @(posedge clk);
    chk(pg_oe, 1'b1);
    wr(OFS_VSEL1, 32'h7f);
    rd(OFS_VSEL1);
    chk(d, 32'h7f);
    wr(OFS_CTRL, 32'h1);
    wait_on(1'b1, 10);
    chk(reg_on, 1'b1);
    ce <= 1'b0;
    repeat (40) @(posedge clk);
    chk(lvl, 12'h000);
    chk(reg_on, 1'b1);
    ce <= 1'b1;
    $display("test software enable done");
  endtask : t_sw_bit

  task t_faults();
    wr(OFS_IRQ_MASK, 32'h1);
    for (int i = 0; i < 3; i++) begin
      flt <= 3'h1 << i;
      wait_on(1'b0, 4);
      repeat (30) @(posedge clk);
      chk(reg_on, 1'b0);
      chk(irq, 1'b1);
      flt <= 3'h0;
      wait_on(1'b1, 10);
      chk(reg_on, 1'b1);
      wr(OFS_IRQ_STAT, 32'h1);
      rd(OFS_IRQ_STAT);
      chk(d[0], 1'b0);
      chk(irq, 1'b0);
    end
    wr(OFS_IRQ_MASK, 32'h0);
    flt <= 3'h4;
    repeat (5) @(posedge clk);
    chk(irq, 1'b0);
    flt <= 3'h0;
    $display("test faults done");
  endtask : t_faults

  task t_pin_low();
    wr(OFS_CTRL, 32'h7);
    en_req <= 1'b0;
    wait_on(1'b0, 5);
    chk(reg_on, 1'b0);
    repeat (3) @(posedge clk);
    chk(pg_oe, 1'b1);
    rd(OFS_CTRL);
    chk(d, 32'h1);
    rd(OFS_VSEL1);
    chk(d, VSEL1_RST);
    wr(OFS_CTRL, 32'h1);
    repeat (5) @(posedge clk);
    chk(reg_on, 1'b0);
    $display("test enable pin low done");
  endtask : t_pin_low

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_power_up();
    t_sw_bit();
    t_faults();
    t_pin_low();
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
